// [verilog/sector_engine_defs.vh]
`ifndef SECTOR_ENGINE_DEFS_VH
`define SECTOR_ENGINE_DEFS_VH

// register word indices (byte address bits 4:2)
`define A_CTRL      3'd0
`define A_ID        3'd1
`define A_PARAM     3'd2
`define A_STATUS    3'd3
`define A_RESULT    3'd4

// control register fields
`define CTRL_OP_LO  0
`define CTRL_OP_HI  2
`define CTRL_MT     3
`define CTRL_SK     4
`define CTRL_HD     5
`define CTRL_START  8

// parameter register fields
`define PAR_EOT_LO  0
`define PAR_GAP_LO  8
`define PAR_FILL_LO 16
`define PAR_IAF     24

// status bit positions
`define ST1_EOC     7
`define ST1_CRC     5
`define ST1_NODATA  2
`define ST1_NOWRITE 1
`define ST2_CTLMARK 6
`define ST2_CRC     5
`define STAT_BUSY   24
`define STAT_IRQ    25

// command codes
`define OP_READ     3'd0
`define OP_READ_DEL 3'd1
`define OP_WRITE    3'd2
`define OP_WRITE_DEL 3'd3
`define OP_TRACK    3'd4
`define OP_READ_ID  3'd5
`define OP_FORMAT   3'd6

// kinds of byte handed to the disk writer
`define K_DATA      3'd0
`define K_GAP       3'd1
`define K_IDMARK    3'd2
`define K_DMARK     3'd3
`define K_DELMARK   3'd4
`define K_IDXMARK   3'd5

// reset values and constants
`define RST_EOT     8'h01
`define RST_GAP     8'h1b
`define RST_FILL    8'he5
`define GAP_BYTE    8'h4e
`define MAX_SIZE    3'd6
`define IDX_LIMIT   2'd2
`define BASE_LEN    14'h0080

`endif

// [verilog/floppy_sector_command_engine.v]
// Behaviour
// - below end sector: report sector plus one
// - at end, no multi-side: sector one, track+1
// - multi-side at end: head flips, sector one
// - read-deleted reads deleted sectors without flag
// - regular mark with skip: flag, skip sector
// - regular mark without skip: read, flag, end
// - write follows read sequencing, host to disk
// - write protect: not-writable bit, abnormal end
// - write-deleted records deleted data mark
// - read-track starts at index, physical order
// - read-track sector compare uses counter from one
// - read-track header mismatch sets no-data, continues
// - read-track ignores CRC, ends at count
// - read-ID returns first header, raises interrupt
// - format waits index, writes whole track pattern
// - format fills data field with fill byte
// - format requests four id bytes per sector
// - format ends at second index, interrupt
// - format: only status bytes meaningful
// - multi-side continues side one at sector one
// - transfers other than read-track continue until terminal count, error or control mark without skip
// - size codes 0..6 give 128..8192 bytes
`timescale 1ns/1ps
`include "sector_engine_defs.vh"
module floppy_sector_command_engine (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // host data path
   output reg         host_req,
   input  wire        host_wr_valid,
   input  wire [7:0]  host_wr_data,
   output reg         host_rd_valid,
   output reg  [7:0]  host_rd_data,
   input  wire        transfer_count_end,
   // drive pins
   input  wire        index_pin,
   input  wire        wprot_pin,
   // recorded fields from the data separator
   input  wire        id_valid,
   input  wire [7:0]  id_track,
   input  wire [7:0]  id_head,
   input  wire [7:0]  id_sector,
   input  wire [7:0]  id_size,
   input  wire        id_crc_err,
   input  wire        mark_valid,
   input  wire        mark_deleted,
   input  wire        rd_valid,
   input  wire [7:0]  rd_data,
   input  wire        rd_crc_err,
   // bytes to the write encoder
   output reg         wr_valid,
   output reg  [7:0]  wr_data,
   output reg  [2:0]  wr_kind,
   // command state
   output reg         busy,
   output reg         result_irq
);

   localparam S_IDLE = 4'd0;
   localparam S_IDX  = 4'd1;
   localparam S_SRCH = 4'd2;
   localparam S_MARK = 4'd3;
   localparam S_XFER = 4'd4;
   localparam S_FID  = 4'd5;
   localparam S_FEMIT = 4'd6;
   localparam S_FEND = 4'd7;
   localparam S_DONE = 4'd8;

   function [2:0] reg_index;
      input [31:0] a;
      begin
         reg_index = (a[31:5] == 27'h0) ? a[4:2] : 3'd7;
      end
   endfunction

   function [13:0] field_len;
      input [7:0] code;
      begin
         if (code > {5'h00, `MAX_SIZE})
            field_len = `BASE_LEN << `MAX_SIZE;
         else
            field_len = `BASE_LEN << code[2:0];
      end
   endfunction

   // result id after a clean end: {track, head, sector}
   function [23:0] next_id;
      input [7:0] trk;
      input [7:0] hd;
      input [7:0] sec;
      input [7:0] end_of_track_sector;
      input       mt;
      begin
         if (sec != end_of_track_sector)
            next_id = {trk, hd, sec + 8'h01};
         else if (!mt)
            next_id = {trk + 8'h01, hd, 8'h01};
         else if (hd[0] == 1'b0)
            next_id = {trk, 8'h01, 8'h01};
         else
            next_id = {trk + 8'h01, 8'h00, 8'h01};
      end
   endfunction

   // pin synchronisers
   reg        idx_s1, idx_s2, idx_s3;
   reg        wp_s1, wp_s2;
   reg        tc_s1, tc_s2;
   // bus data phase
   reg        wr_pend_q;
   reg [2:0]  wr_idx_q;
   // software state
   reg [2:0]  op_q;
   reg        mt_q, sk_q, iaf_q;
   reg [7:0]  ptrk_q, phd_q, psec_q, psz_q;
   reg [7:0]  eot_q, gap_q, fill_q;
   reg [7:0]  st0_q, st1_q, st2_q;
   reg [7:0]  rtrk_q, rhd_q, rsec_q, rsz_q;
   reg        start_q;
   // engine state
   reg [3:0]  state_q;
   reg [7:0]  ctrk_q, chd_q, csec_q, csz_q;
   reg [1:0]  idx_cnt_q;
   reg [13:0] cnt_q;
   reg [2:0]  phase_q;
   reg        tc_seen_q, abn_q, keep_q, stop_q, deleted_q;
   reg [7:0]  fid_q [0:3];

   wire idx_edge = idx_s2 & ~idx_s3;
   wire is_write = (op_q == `OP_WRITE) | (op_q == `OP_WRITE_DEL);
   wire bus_req  = hsel & htrans[1] & hready;
   wire id_match = (id_track == ctrk_q) & (id_head == chd_q) &
                   (id_sector == csec_q) & (id_size == csz_q);
   wire [23:0] nid = next_id(ctrk_q, chd_q, csec_q, eot_q, mt_q);

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         idx_s1 <= 1'b0;
         idx_s2 <= 1'b0;
         idx_s3 <= 1'b0;
         wp_s1  <= 1'b0;
         wp_s2  <= 1'b0;
         tc_s1  <= 1'b0;
         tc_s2  <= 1'b0;
      end else begin
         idx_s1 <= index_pin;
         idx_s2 <= idx_s1;
         idx_s3 <= idx_s2;
         wp_s1  <= wprot_pin;
         wp_s2  <= wp_s1;
         tc_s1  <= transfer_count_end;
         tc_s2  <= tc_s1;
      end
   end

   // register file: zero-wait, write data applied in the data phase
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 3'd0;
         op_q      <= `OP_READ;
         mt_q      <= 1'b0;
         sk_q      <= 1'b0;
         iaf_q     <= 1'b0;
         ptrk_q    <= 8'h00;
         phd_q     <= 8'h00;
         psec_q    <= 8'h01;
         psz_q     <= 8'h02;
         eot_q     <= `RST_EOT;
         gap_q     <= `RST_GAP;
         fill_q    <= `RST_FILL;
         start_q   <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         start_q   <= 1'b0;
         wr_pend_q <= bus_req & hwrite;
         wr_idx_q  <= reg_index(haddr);
         if (bus_req & ~hwrite) begin
            case (reg_index(haddr))
               `A_CTRL:   hrdata <= {26'h0, chd_q[0], sk_q, mt_q, op_q};
               `A_ID:     hrdata <= {psz_q, psec_q, phd_q, ptrk_q};
               `A_PARAM:  hrdata <= {7'h0, iaf_q, fill_q, gap_q, eot_q};
               `A_STATUS: hrdata <= {6'h0, result_irq, busy, st2_q, st1_q, st0_q};
               `A_RESULT: hrdata <= {rsz_q, rsec_q, rhd_q, rtrk_q};
               default:   hrdata <= 32'h0;
            endcase
         end
         // parameters are locked while a command runs
         if (wr_pend_q & ~busy) begin
            case (wr_idx_q)
               `A_CTRL: begin
                  op_q    <= hwdata[`CTRL_OP_HI:`CTRL_OP_LO];
                  mt_q    <= hwdata[`CTRL_MT];
                  sk_q    <= hwdata[`CTRL_SK];
                  phd_q   <= {7'h0, hwdata[`CTRL_HD]};
                  start_q <= hwdata[`CTRL_START];
               end
               `A_ID: begin
                  ptrk_q <= hwdata[7:0];
                  psec_q <= hwdata[23:16];
                  psz_q  <= hwdata[31:24];
               end
               `A_PARAM: begin
                  eot_q  <= hwdata[`PAR_EOT_LO +: 8];
                  gap_q  <= hwdata[`PAR_GAP_LO +: 8];
                  fill_q <= hwdata[`PAR_FILL_LO +: 8];
                  iaf_q  <= hwdata[`PAR_IAF];
               end
               default: ;
            endcase
         end
      end
   end

   // command engine
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= S_IDLE;
         busy <= 1'b0;
         result_irq <= 1'b0;
         host_req <= 1'b0;
         host_rd_valid <= 1'b0;
         host_rd_data <= 8'h00;
         wr_valid <= 1'b0;
         wr_data <= 8'h00;
         wr_kind <= `K_DATA;
         st0_q <= 8'h00;
         st1_q <= 8'h00;
         st2_q <= 8'h00;
         rtrk_q <= 8'h00;
         rhd_q <= 8'h00;
         rsec_q <= 8'h00;
         rsz_q <= 8'h00;
         ctrk_q <= 8'h00;
         chd_q <= 8'h00;
         csec_q <= 8'h00;
         csz_q <= 8'h00;
         idx_cnt_q <= 2'd0;
         cnt_q <= 14'h0;
         phase_q <= 3'd0;
         tc_seen_q <= 1'b0;
         abn_q <= 1'b0;
         keep_q <= 1'b0;
         stop_q <= 1'b0;
         deleted_q <= 1'b0;
         fid_q[0] <= 8'h00;
         fid_q[1] <= 8'h00;
         fid_q[2] <= 8'h00;
         fid_q[3] <= 8'h00;
      end else begin
         host_rd_valid <= 1'b0;
         wr_valid <= 1'b0;
         if (busy & tc_s2)
            tc_seen_q <= 1'b1;
         // reading the result acknowledges the interrupt
         if (bus_req & ~hwrite & (reg_index(haddr) == `A_RESULT))
            result_irq <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (start_q) begin
                  busy <= 1'b1;
                  result_irq <= 1'b0;
                  st0_q <= 8'h00;
                  st1_q <= 8'h00;
                  st2_q <= 8'h00;
                  ctrk_q <= ptrk_q;
                  chd_q <= phd_q;
                  csec_q <= (op_q == `OP_TRACK) ? 8'h01 : psec_q;
                  csz_q <= psz_q;
                  idx_cnt_q <= 2'd0;
                  phase_q <= 3'd0;
                  tc_seen_q <= 1'b0;
                  abn_q <= 1'b0;
                  keep_q <= (op_q == `OP_TRACK) | (op_q == `OP_FORMAT);
                  stop_q <= 1'b0;
                  if ((is_write | (op_q == `OP_FORMAT)) & wp_s2) begin
                     st1_q[`ST1_NOWRITE] <= 1'b1;
                     abn_q <= 1'b1;
                     state_q <= S_DONE;
                  end else if ((op_q == `OP_TRACK) | (op_q == `OP_FORMAT))
                     state_q <= S_IDX;
                  else
                     state_q <= S_SRCH;
               end
            end
            S_IDX: begin
               if (idx_edge) begin
                  if (op_q == `OP_FORMAT) begin
                     host_req <= 1'b1;
                     cnt_q <= 14'h0;
                     if (iaf_q) begin
                        wr_valid <= 1'b1;
                        wr_kind <= `K_IDXMARK;
                        wr_data <= 8'h00;
                     end
                     state_q <= S_FID;
                  end else
                     state_q <= S_SRCH;
               end
            end
            S_SRCH: begin
               if (id_valid & (op_q == `OP_READ_ID)) begin
                  ctrk_q <= id_track;
                  chd_q <= id_head;
                  csec_q <= id_sector;
                  csz_q <= id_size;
                  keep_q <= 1'b1;
                  state_q <= S_DONE;
               end else if (id_valid & (op_q == `OP_TRACK)) begin
                  if (~id_match)
                     st1_q[`ST1_NODATA] <= 1'b1;
                  state_q <= S_MARK;
               end else if (id_valid & id_match) begin
                  if (id_crc_err) begin
                     st1_q[`ST1_CRC] <= 1'b1;
                     abn_q <= 1'b1;
                     state_q <= S_DONE;
                  end else if (is_write) begin
                     wr_valid <= 1'b1;
                     wr_data <= 8'h00;
                     wr_kind <= (op_q == `OP_WRITE_DEL) ? `K_DELMARK : `K_DMARK;
                     cnt_q <= field_len(csz_q);
                     host_req <= 1'b1;
                     state_q <= S_XFER;
                  end else
                     state_q <= S_MARK;
               end else if (idx_edge) begin
                  idx_cnt_q <= idx_cnt_q + 2'd1;
                  if (idx_cnt_q + 2'd1 == `IDX_LIMIT) begin
                     st1_q[`ST1_NODATA] <= 1'b1;
                     abn_q <= 1'b1;
                     state_q <= S_DONE;
                  end
               end
            end
            S_MARK: begin
               if (mark_valid) begin
                  cnt_q <= field_len(csz_q);
                  deleted_q <= 1'b0;
                  state_q <= S_XFER;
                  if ((op_q == `OP_READ_DEL) & ~mark_deleted) begin
                     st2_q[`ST2_CTLMARK] <= 1'b1;
                     if (sk_q)
                        deleted_q <= 1'b1;
                     else
                        stop_q <= 1'b1;
                  end else if ((op_q == `OP_READ) & mark_deleted) begin
                     st2_q[`ST2_CTLMARK] <= 1'b1;
                     if (sk_q)
                        deleted_q <= 1'b1;
                     else
                        stop_q <= 1'b1;
                  end
               end
            end
            S_XFER: begin
               // skipped sectors still pass under the head, but reach no host
               if (~is_write & rd_valid) begin
                  host_rd_valid <= ~deleted_q;
                  host_rd_data <= rd_data;
                  cnt_q <= cnt_q - 14'h1;
                  if ((cnt_q == 14'h1) & rd_crc_err & (op_q != `OP_TRACK)) begin
                     st1_q[`ST1_CRC] <= 1'b1;
                     st2_q[`ST2_CRC] <= 1'b1;
                     abn_q <= 1'b1;
                     state_q <= S_DONE;
                  end
               end
               if (is_write & host_wr_valid) begin
                  wr_valid <= 1'b1;
                  wr_kind <= `K_DATA;
                  wr_data <= host_wr_data;
                  cnt_q <= cnt_q - 14'h1;
                  if (cnt_q == 14'h1)
                     host_req <= 1'b0;
               end
               if (cnt_q == 14'h0) begin
                  idx_cnt_q <= 2'd0;
                  if (op_q == `OP_TRACK) begin
                     csec_q <= csec_q + 8'h01;
                     state_q <= (csec_q == eot_q) ? S_DONE : S_SRCH;
                  end else if (stop_q | (tc_seen_q & ~deleted_q))
                     state_q <= S_DONE;
                  else if (csec_q != eot_q) begin
                     csec_q <= csec_q + 8'h01;
                     state_q <= S_SRCH;
                  end else if (mt_q & ~chd_q[0]) begin
                     chd_q <= 8'h01;
                     csec_q <= 8'h01;
                     state_q <= S_SRCH;
                  end else begin
                     st1_q[`ST1_EOC] <= 1'b1;
                     abn_q <= 1'b1;
                     state_q <= S_DONE;
                  end
               end
            end
            S_FID: begin
               if (host_wr_valid) begin
                  fid_q[cnt_q[1:0]] <= host_wr_data;
                  cnt_q <= cnt_q + 14'h1;
                  if (cnt_q[1:0] == 2'd3) begin
                     host_req <= 1'b0;
                     phase_q <= 3'd0;
                     cnt_q <= 14'h0;
                     state_q <= S_FEMIT;
                  end
               end
            end
            S_FEMIT: begin
               wr_valid <= 1'b1;
               cnt_q <= cnt_q + 14'h1;
               case (phase_q)
                  3'd0: begin
                     wr_kind <= `K_IDMARK;
                     wr_data <= 8'h00;
                     phase_q <= 3'd1;
                     cnt_q <= 14'h0;
                  end
                  3'd1: begin
                     wr_kind <= `K_DATA;
                     wr_data <= fid_q[cnt_q[1:0]];
                     if (cnt_q[1:0] == 2'd3) begin
                        phase_q <= 3'd2;
                        cnt_q <= 14'h0;
                     end
                  end
                  3'd2: begin
                     wr_kind <= `K_DMARK;
                     wr_data <= 8'h00;
                     phase_q <= 3'd3;
                     cnt_q <= 14'h0;
                  end
                  3'd3: begin
                     wr_kind <= `K_DATA;
                     wr_data <= fill_q;
                     if (cnt_q == field_len(csz_q) - 14'h1) begin
                        phase_q <= 3'd4;
                        cnt_q <= 14'h0;
                     end
                  end
                  default: begin
                     wr_kind <= `K_GAP;
                     wr_data <= `GAP_BYTE;
                     if (cnt_q == {6'h0, gap_q} - 14'h1) begin
                        cnt_q <= 14'h0;
                        csec_q <= csec_q + 8'h01;
                        if (csec_q == eot_q)
                           state_q <= S_FEND;
                        else begin
                           host_req <= 1'b1;
                           state_q <= S_FID;
                        end
                     end
                  end
               endcase
            end
            S_FEND: begin
               wr_valid <= ~idx_edge;
               wr_kind <= `K_GAP;
               wr_data <= `GAP_BYTE;
               if (idx_edge)
                  state_q <= S_DONE;
            end
            S_DONE: begin
               busy <= 1'b0;
               host_req <= 1'b0;
               result_irq <= 1'b1;
               st0_q <= {abn_q ? 2'b01 : 2'b00, 3'b000, chd_q[0], 2'b00};
               // after format the id bytes are whatever the engine last held
               rsz_q <= csz_q;
               if (abn_q | keep_q) begin
                  rtrk_q <= ctrk_q;
                  rhd_q <= chd_q;
                  rsec_q <= csec_q;
               end else begin
                  rtrk_q <= nid[23:16];
                  rhd_q <= nid[15:8];
                  rsec_q <= nid[7:0];
               end
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

endmodule

// [tb/floppy_sector_command_engine_chk.sv]
`timescale 1ns/1ps
`include "sector_engine_defs.vh"
module floppy_sector_command_engine_chk (
   // clock and reset
   input wire        clk,
   input wire        reset,
   // register bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hwdata,
   input wire        hreadyout,
   input wire        hresp,
   // data path and state
   input wire        host_req,
   input wire        host_rd_valid,
   input wire        rd_valid,
   input wire        wr_valid,
   input wire [2:0]  wr_kind,
   input wire        busy,
   input wire        result_irq
);
   logic ctrl_wr_q;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_wr_q <= 1'b0;
      end else if (hready) begin
         ctrl_wr_q <= hsel && htrans[1] && hwrite && haddr == 32'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_zero_wait: assert property (hreadyout)
      else $error("bus wait state inserted");
   a_start_busy: assert property (ctrl_wr_q && hwdata[8] && !busy && !result_irq |->
      ##[1:3] (busy || result_irq))
      else $error("start did not launch a command");
   a_done_irq: assert property ($fell(busy) |-> result_irq)
      else $error("command ended without result flag");
   a_irq_idle: assert property (result_irq |-> !busy)
      else $error("result flag while busy");
   a_read_follows: assert property (host_rd_valid |-> $past(rd_valid))
      else $error("host byte without disk byte");
   a_quiet_idle: assert property (!busy && !$past(busy) |-> !host_req && !host_rd_valid)
      else $error("host traffic while idle");
   a_kind_legal: assert property (wr_valid |-> wr_kind <= `K_IDXMARK)
      else $error("unknown byte kind to encoder");
endmodule
bind floppy_sector_command_engine floppy_sector_command_engine_chk chk (
   .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp,
   .host_req, .host_rd_valid, .rd_valid, .wr_valid, .wr_kind, .busy, .result_irq);

// [tb/floppy_drive_model.sv]
`timescale 1ns/1ps
module floppy_drive_model (
   // bench controls
   input  wire        clk,
   input  wire [7:0]  trk,
   input  wire [7:0]  hd,
   input  wire        del,
   // drive and separator side
   output logic       index_pin,
   output logic       id_valid,
   output wire  [7:0] id_track,
   output wire  [7:0] id_head,
   output wire  [7:0] id_sector,
   output wire  [7:0] id_size,
   output logic       id_crc_err,
   output logic       mark_valid,
   output logic       mark_deleted,
   output logic       rd_valid,
   output logic [7:0] rd_data,
   output logic       rd_crc_err
);
   logic [31:0] hdr;
   assign {id_track, id_head, id_sector, id_size} = hdr;
   // fields outside their pulse show inverted values so stale data never matches
   initial begin
      {index_pin, id_valid, id_crc_err, mark_valid, mark_deleted} = 5'h00;
      {rd_valid, rd_crc_err, rd_data, hdr} = 42'h0;
      forever begin
         repeat (6) @(posedge clk);
         index_pin <= 1'b1;
         repeat (4) @(posedge clk);
         index_pin <= 1'b0;
         for (int s = 1; s <= 6; s++) begin
            repeat (12) @(posedge clk);
            {id_valid, hdr} <= {1'b1, trk, hd, 8'(s), 8'h00};
            @(posedge clk);
            {id_valid, hdr} <= {1'b0, ~hdr};
            repeat (3) @(posedge clk);
            {mark_valid, mark_deleted} <= {1'b1, del};
            @(posedge clk);
            {mark_valid, mark_deleted} <= {1'b0, ~del};
            for (int b = 0; b < 128; b++) begin
               @(posedge clk);
               {rd_valid, rd_data} <= {1'b1, 8'(b) ^ 8'h5a};
               @(posedge clk);
               {rd_valid, rd_data} <= {1'b0, ~rd_data};
            end
         end
      end
   end
endmodule

// [tb/floppy_sector_command_engine_test.sv]
`timescale 1ns/1ps
`include "sector_engine_defs.vh"
module floppy_sector_command_engine_test;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic        host_wr_valid = 1'b0;
   logic [7:0]  host_wr_data = 8'h00;
   logic        wprot = 1'b0;
   logic        mdel = 1'b0;
   logic [7:0]  mtrk = 8'h00;
   logic [7:0]  mhd = 8'h00;
   wire         hready, hreadyout, hresp, host_req, host_rd_valid, busy, result_irq;
   wire         index_pin, id_valid, id_crc_err, mark_valid, mark_deleted, rd_valid;
   wire         rd_crc_err, wr_valid;
   wire  [2:0]  wr_kind;
   wire  [7:0]  id_track, id_head, id_sector, id_size, rd_data, wr_data, host_rd_data;
   wire  [31:0] hrdata;
   int          checks = 0;
   int          fail_count = 0;
   logic [7:0]  rdn = 8'h0, dn = 8'h0, dm = 8'h0, xm = 8'h0;
   logic [31:0] seed = 32'h29;
   // op, then multi-side, head, deleted mark, then sector and end sector
   localparam logic [21:0] cases [7] = '{
      {3'h1, 3'h0, 8'h02, 8'h05}, {3'h1, 3'h3, 8'h04, 8'h04}, {3'h1, 3'h5, 8'h03, 8'h03},
      {3'h1, 3'h7, 8'h05, 8'h05}, {3'h0, 3'h4, 8'h01, 8'h03}, {3'h2, 3'h0, 8'h02, 8'h02},
      {3'h3, 3'h6, 8'h01, 8'h02}};
   floppy_sector_command_engine DUT (
      .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .host_req, .host_wr_valid, .host_wr_data,
      .host_rd_valid, .host_rd_data, .transfer_count_end(1'b1), .index_pin,
      .wprot_pin(wprot), .id_valid, .id_track, .id_head, .id_sector, .id_size,
      .id_crc_err, .mark_valid, .mark_deleted, .rd_valid, .rd_data, .rd_crc_err,
      .wr_valid, .wr_data, .wr_kind, .busy, .result_irq);
   floppy_drive_model drive (
      .clk, .trk(mtrk), .hd(mhd), .del(mdel), .index_pin, .id_valid, .id_track,
      .id_head, .id_sector, .id_size, .id_crc_err, .mark_valid, .mark_deleted,
      .rd_valid, .rd_data, .rd_crc_err);
   always #2.5 clk = ~clk;
   assign hready = hreadyout;
   always @(posedge clk) begin
      host_wr_valid <= host_req && !host_wr_valid;
      host_wr_data <= host_wr_data + 8'h01;
      if (hsel && hwrite)
         {rdn, dn, dm, xm} <= 32'h0;
      else begin
         rdn <= rdn + (host_rd_valid === 1'b1 ? host_rd_data : 8'h00);
         dn <= dn + {7'h0, wr_valid === 1'b1 && wr_kind === `K_DATA};
         dm <= dm + {7'h0, wr_valid === 1'b1 && wr_kind === `K_DMARK};
         xm <= xm + {7'h0, wr_valid === 1'b1 && wr_kind === `K_DELMARK};
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] next_id(input logic [7:0] t, h, s, e, input logic mt);
      if (s != e) return {8'h00, s + 8'h01, h, t};
      if (!mt) return {8'h00, 8'h01, h, t + 8'h01};
      return h[0] ? {8'h00, 8'h01, 8'h00, t + 8'h01} : {8'h00, 8'h01, 8'h01, t};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, wr};
      do @(posedge clk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic run_cmd(input logic [31:0] ctrl, output logic [31:0] st, res);
      bus(1'b1, 32'h0, ctrl | 32'h100, st);
      do @(posedge clk); while (result_irq !== 1'b1);
      bus(1'b0, 32'hc, 32'h0, st);
      bus(1'b0, 32'h10, 32'h0, res);
   endtask
   task automatic conclude();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      conclude();
   end
   initial begin
      logic [31:0] q, st, res;
      logic [2:0]  op;
      logic        mt, hh, dl;
      logic [7:0]  sec, end_of_track_sector, trk;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      bus(1'b0, 32'h8, 32'h0, q);
      check(q, {8'h00, `RST_FILL, `RST_GAP, `RST_EOT});
      bus(1'b0, 32'h14, 32'h0, q);
      check(q, 32'h0);
      for (int i = 0; i < 7; i++) begin
         {op, mt, hh, dl, sec, end_of_track_sector} = cases[i];
         seed = xs(seed);
         trk = seed[7:0] & 8'hfe;
         {mtrk, mhd, mdel} <= {trk, 7'h00, hh, dl};
         bus(1'b1, 32'h8, {8'h00, `RST_FILL, `RST_GAP, end_of_track_sector}, q);
         bus(1'b1, 32'h4, {8'h00, sec, 8'h00, trk}, q);
         run_cmd({26'h0, hh, 1'b0, mt, op}, st, res);
         check(res, next_id(trk, {7'h00, hh}, sec, end_of_track_sector, mt));
         check({29'h0, st[7:6], st[22]}, {31'h0, (op == `OP_READ_DEL) ^ dl});
         check({rdn, dn, dm, xm}, {op < 3'h2 ? 8'hc0 : 8'd0, op < 3'h2 ? 8'd0 : 8'd128,
            7'h0, op == `OP_WRITE, 7'h0, op == `OP_WRITE_DEL});
      end
      // skip set over regular marks: both sectors pass by
      run_cmd(32'h31, st, res);
      check({st[23:0], rdn}, 32'h40804400);
      check(res, {16'h0002, mhd, mtrk});
      wprot <= 1'b1;
      repeat (4) @(posedge clk);
      run_cmd({29'h0, `OP_WRITE}, st, res);
      check({29'h0, st[7:6], st[9]}, 32'h3);
      wprot <= 1'b0;
      repeat (4) @(posedge clk);
      run_cmd({29'h0, `OP_READ_ID}, st, res);
      check({res[31:24], res[15:0], rdn}, {8'h00, mhd, mtrk, 8'h00});
      conclude();
   end
endmodule
